// File: design/pac_autoneg_ctrl.sv
// Purpose: Negotiation control and LED off registers for two copper ports
// Assumes: Register strobes are one-cycle pulses synchronous to core_clk
// Notes: Straps must be steady at reset release
`default_nettype none

module pac_autoneg_ctrl
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rd_valid,
    input wire logic port1_led_low_strap,
    input wire logic port1_led_high_strap,
    input wire logic port1_duplex_strap,
    input wire logic port2_negotiation_strap,
    input wire logic port2_speed_strap,
    input wire logic port2_duplex_strap,
    input wire logic [1:0] an_complete,
    input wire logic [1:0] an_failed,
    input wire logic [1:0] neg_speed_100,
    input wire logic [1:0] neg_duplex_full,
    input wire logic [1:0] detect_speed_100,
    input wire logic [1:0] led_drive_a,
    input wire logic [1:0] led_drive_b,
    output logic [1:0] an_enable,
    output logic [1:0] adv_pause,
    output logic [1:0] adv_100_full,
    output logic [1:0] adv_100_half,
    output logic [1:0] adv_10_full,
    output logic [1:0] adv_10_half,
    output logic [1:0] link_speed_100,
    output logic [1:0] link_duplex_full,
    output logic [1:0] port_led_output_a,
    output logic [1:0] port_led_output_b
);
    import pac_pkg::*;

    // ----------------------------------------------------------------
    // Address decode
    // ----------------------------------------------------------------
    function automatic pac_sel_t decode_sel(input logic [7:0] addr, output logic port);
        port = 1'h0;
        decode_sel = PAC_SEL_NONE;
        case (addr)
            PAC_P1_NEG_CTRL_OFS:
            begin
                decode_sel = PAC_SEL_NEG;
            end
            PAC_P1_LED_CTRL_OFS:
            begin
                decode_sel = PAC_SEL_LED;
            end
            PAC_P2_NEG_CTRL_OFS:
            begin
                port = 1'h1;
                decode_sel = PAC_SEL_NEG;
            end
            PAC_P2_LED_CTRL_OFS:
            begin
                port = 1'h1;
                decode_sel = PAC_SEL_LED;
            end
            default:
            begin
                decode_sel = PAC_SEL_NONE;
            end
        endcase
    endfunction

    logic [7:0] neg_ctrl_reg [PAC_NUM_PORTS];
    logic [1:0] led_off_reg;
    logic strap_done_reg;
    logic [2:0] strap_bits [PAC_NUM_PORTS];
    pac_sel_t wr_sel;
    pac_sel_t rd_sel;
    logic wr_port;
    logic rd_port;
    logic [7:0] reg_rdata_next;

    always_comb
    begin
        wr_sel = decode_sel(reg_addr, wr_port);
        rd_sel = decode_sel(reg_addr, rd_port);
    end

    assign strap_bits[0] = {port1_led_low_strap, port1_led_high_strap, port1_duplex_strap};
    assign strap_bits[1] = {port2_negotiation_strap, port2_speed_strap, port2_duplex_strap};

    // ----------------------------------------------------------------
    // Strap capture
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            strap_done_reg <= 1'h0;
        end
        else
        begin
            strap_done_reg <= 1'h1;
        end
    end

    // ----------------------------------------------------------------
    // Negotiation control registers
    // ----------------------------------------------------------------
    // per-port control storage
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            neg_ctrl_reg[0] <= PAC_NEG_CTRL_RESET;
            neg_ctrl_reg[1] <= PAC_NEG_CTRL_RESET;
        end
        else if (!strap_done_reg)
        begin
            for (int i = 0; i < PAC_NUM_PORTS; i++)
            begin
                neg_ctrl_reg[i][PAC_AN_EN_BIT:PAC_FORCE_DUPLEX_BIT] <= strap_bits[i];
            end
        end
        else if (reg_wr_en && wr_sel == PAC_SEL_NEG)
        begin
            neg_ctrl_reg[wr_port] <= reg_wdata;
        end
    end

    // ----------------------------------------------------------------
    // LED off registers
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_off_reg <= {2{PAC_LED_OFF_RESET}};
        end
        else if (strap_done_reg && reg_wr_en && wr_sel == PAC_SEL_LED)
        begin
            led_off_reg[wr_port] <= reg_wdata[PAC_LED_OFF_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Read path
    // ----------------------------------------------------------------
    always_comb
    begin
        reg_rdata_next = PAC_READ_ZERO;
        case (rd_sel)
            PAC_SEL_NEG:
            begin
                reg_rdata_next = neg_ctrl_reg[rd_port];
            end
            PAC_SEL_LED:
            begin
                reg_rdata_next[PAC_LED_OFF_BIT] = led_off_reg[rd_port];
            end
            default:
            begin
                reg_rdata_next = PAC_READ_ZERO;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_rdata <= PAC_READ_ZERO;
            reg_rd_valid <= 1'h0;
        end
        else
        begin
            reg_rd_valid <= reg_rd_en;
            if (reg_rd_en)
            begin
                reg_rdata <= reg_rdata_next;
            end
        end
    end

    // ----------------------------------------------------------------
    // Advertised abilities and port logic
    // ----------------------------------------------------------------
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            an_enable <= 2'h3;
            adv_pause <= 2'h3;
            adv_100_full <= 2'h3;
            adv_100_half <= 2'h3;
            adv_10_full <= 2'h3;
            adv_10_half <= 2'h3;
        end
        else
        begin
            for (int i = 0; i < PAC_NUM_PORTS; i++)
            begin
                an_enable[i] <= neg_ctrl_reg[i][PAC_AN_EN_BIT];
                adv_pause[i] <= neg_ctrl_reg[i][PAC_ADV_PAUSE_BIT];
                adv_100_full[i] <= neg_ctrl_reg[i][PAC_ADV_100FD_BIT];
                adv_100_half[i] <= neg_ctrl_reg[i][PAC_ADV_100HD_BIT];
                adv_10_full[i] <= neg_ctrl_reg[i][PAC_ADV_10FD_BIT];
                adv_10_half[i] <= neg_ctrl_reg[i][PAC_ADV_10HD_BIT];
            end
        end
    end

    for (genvar g = 0; g < PAC_NUM_PORTS; g++)
    begin : g_port
        pac_link_resolve u_resolve (
            .core_clk(core_clk),
            .rst_n(rst_n),
            .an_enable(neg_ctrl_reg[g][PAC_AN_EN_BIT]),
            .force_speed_100(neg_ctrl_reg[g][PAC_FORCE_SPEED_BIT]),
            .force_duplex_full(neg_ctrl_reg[g][PAC_FORCE_DUPLEX_BIT]),
            .led_off(led_off_reg[g]),
            .an_complete(an_complete[g]),
            .an_failed(an_failed[g]),
            .neg_speed_100(neg_speed_100[g]),
            .neg_duplex_full(neg_duplex_full[g]),
            .detect_speed_100(detect_speed_100[g]),
            .led_drive_a(led_drive_a[g]),
            .led_drive_b(led_drive_b[g]),
            .speed_100(link_speed_100[g]),
            .duplex_full(link_duplex_full[g]),
            .led_out_a(port_led_output_a[g]),
            .led_out_b(port_led_output_b[g])
        );

        AST_FORCED_MODE: assert property (@(posedge core_clk) disable iff (!rst_n)
            (!neg_ctrl_reg[g][PAC_AN_EN_BIT] ##1 !neg_ctrl_reg[g][PAC_AN_EN_BIT])
            |-> (link_speed_100[g] == $past(neg_ctrl_reg[g][PAC_FORCE_SPEED_BIT])
            && link_duplex_full[g] == $past(neg_ctrl_reg[g][PAC_FORCE_DUPLEX_BIT])))
            else $error("Forced mode not applied");

        // forced 10 when speed bit clear
        AST_FORCED_TEN: assert property (@(posedge core_clk) disable iff (!rst_n)
            (!neg_ctrl_reg[g][PAC_AN_EN_BIT] && !neg_ctrl_reg[g][PAC_FORCE_SPEED_BIT])
            |=> !link_speed_100[g])
            else $error("Forced speed not 10");

        AST_LED_WRITE: assert property (@(posedge core_clk) disable iff (!rst_n)
            (strap_done_reg && reg_wr_en && reg_addr == (g == 0 ? PAC_P1_LED_CTRL_OFS
            : PAC_P2_LED_CTRL_OFS) && reg_wdata[PAC_LED_OFF_BIT])
            |-> ##2 (port_led_output_a[g] && port_led_output_b[g]))
            else $error("LED off write not effective");

        AST_STRAP_LOAD: assert property (@(posedge core_clk) disable iff (!rst_n)
            !strap_done_reg |=> (neg_ctrl_reg[g][PAC_AN_EN_BIT:PAC_FORCE_DUPLEX_BIT]
            == $past(strap_bits[g])))
            else $error("Strap value not captured");

        AST_ADV_PAUSE: assert property (@(posedge core_clk) disable iff (!rst_n)
            adv_pause[g] == $past(neg_ctrl_reg[g][PAC_ADV_PAUSE_BIT]))
            else $error("Pause advertisement mismatch");

        AST_ADV_ABILITY: assert property (@(posedge core_clk) disable iff (!rst_n)
            {adv_100_full[g], adv_100_half[g], adv_10_full[g], adv_10_half[g]}
            == $past(neg_ctrl_reg[g][PAC_ADV_100FD_BIT:PAC_ADV_10HD_BIT]))
            else $error("Ability advertisement mismatch");
    end

    AST_NEG_READBACK: assert property (@(posedge core_clk) disable iff (!rst_n)
        (strap_done_reg && reg_wr_en && reg_addr == PAC_P2_NEG_CTRL_OFS)
        ##1 !reg_wr_en
        ##1 (reg_rd_en && !reg_wr_en && reg_addr == PAC_P2_NEG_CTRL_OFS)
        |=> (reg_rd_valid && reg_rdata == $past(reg_wdata, 3)))
        else $error("Control readback mismatch");

    // reserved port 3 location reads zero
    AST_RESERVED_ZERO: assert property (@(posedge core_clk) disable iff (!rst_n)
        (reg_rd_en && reg_addr[7:4] == 4'h3) |=> (reg_rdata == PAC_READ_ZERO))
        else $error("Reserved read not zero");
endmodule // pac_autoneg_ctrl

`default_nettype wire

// File: design/pac_link_resolve.sv
// Purpose: Resolve one port's link speed, duplex and LED pin levels
// Assumes: Negotiation status inputs are synchronous to core_clk
// Notes: All outputs registered
`default_nettype none

module pac_link_resolve
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic an_enable,
    input wire logic force_speed_100,
    input wire logic force_duplex_full,
    input wire logic led_off,
    input wire logic an_complete,
    input wire logic an_failed,
    input wire logic neg_speed_100,
    input wire logic neg_duplex_full,
    input wire logic detect_speed_100,
    input wire logic led_drive_a,
    input wire logic led_drive_b,
    output logic speed_100,
    output logic duplex_full,
    output logic led_out_a,
    output logic led_out_b
);
    import pac_pkg::*;

    // ----------------------------------------------------------------
    // Link mode
    // ----------------------------------------------------------------
    // forced or negotiated mode
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            speed_100 <= 1'h0;
            duplex_full <= 1'h0;
        end
        else if (!an_enable)
        begin
            speed_100 <= force_speed_100;
            duplex_full <= force_duplex_full;
        end
        else if (an_failed)
        begin
            speed_100 <= detect_speed_100;
            duplex_full <= force_duplex_full;
        end
        else if (an_complete)
        begin
            speed_100 <= neg_speed_100;
            duplex_full <= neg_duplex_full;
        end
    end

    // ----------------------------------------------------------------
    // LED pins
    // ----------------------------------------------------------------
    // LED off forces high
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            led_out_a <= PAC_LED_IDLE;
            led_out_b <= PAC_LED_IDLE;
        end
        else
        begin
            led_out_a <= led_off ? PAC_LED_IDLE : led_drive_a;
            led_out_b <= led_off ? PAC_LED_IDLE : led_drive_b;
        end
    end

    AST_LED_OFF_HIGH: assert property (@(posedge core_clk) disable iff (!rst_n)
        led_off |=> (led_out_a && led_out_b))
        else $error("LED not high while off");

    AST_FAIL_DUPLEX: assert property (@(posedge core_clk) disable iff (!rst_n)
        (an_enable && an_failed) |=> (duplex_full == $past(force_duplex_full)))
        else $error("Failed negotiation duplex wrong");
endmodule // pac_link_resolve

`default_nettype wire

// File: design/pac_pkg.sv
// Purpose: Constants for the copper port negotiation and LED control block
// Assumes: Byte-wide register port, two copper ports, 25 MHz core clock
// Notes: Port index 0 is copper port 1, index 1 is copper port 2
`default_nettype none

package pac_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [7:0] PAC_P1_NEG_CTRL_OFS = 8'h1C;
    localparam logic [7:0] PAC_P1_LED_CTRL_OFS = 8'h1D;
    localparam logic [7:0] PAC_P2_NEG_CTRL_OFS = 8'h2C;
    localparam logic [7:0] PAC_P2_LED_CTRL_OFS = 8'h2D;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PAC_AN_EN_BIT = 7;
    localparam int PAC_FORCE_SPEED_BIT = 6;
    localparam int PAC_FORCE_DUPLEX_BIT = 5;
    localparam int PAC_ADV_PAUSE_BIT = 4;
    localparam int PAC_ADV_100FD_BIT = 3;
    localparam int PAC_ADV_100HD_BIT = 2;
    localparam int PAC_ADV_10FD_BIT = 1;
    localparam int PAC_ADV_10HD_BIT = 0;
    localparam int PAC_LED_OFF_BIT = 7;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] PAC_NEG_CTRL_RESET = 8'hFF;
    localparam logic PAC_LED_OFF_RESET = 1'h0;
    localparam logic PAC_LED_IDLE = 1'h1;
    localparam logic [7:0] PAC_READ_ZERO = 8'h00;
    localparam int PAC_NUM_PORTS = 2;

    typedef enum logic [1:0] {
        PAC_SEL_NONE,
        PAC_SEL_NEG,
        PAC_SEL_LED
    } pac_sel_t;
endpackage : pac_pkg

`default_nettype wire

// File: verification/pac_link_partner.sv
// Purpose: Remote link partner model for one copper port
// Assumes: Ability order 100 full, 100 half, 10 full, 10 half
// Notes: Restarts whenever negotiation is off or the offer changes
`default_nettype none

module pac_link_partner
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic an_enable,
    input wire logic [3:0] adv,
    input wire logic [3:0] ability,
    output logic an_complete,
    output logic an_failed,
    output logic neg_speed_100,
    output logic neg_duplex_full,
    output logic detect_speed_100
);
    timeunit 1ns;
    timeprecision 1ps;
    // ----------------------------------------------------------------
    // Negotiation
    // ----------------------------------------------------------------
    logic [3:0] common;
    logic [3:0] last_adv;
    logic [3:0] cnt;
    assign common = adv & ability;
    always_ff @(posedge core_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            last_adv <= 4'hF;
            cnt <= 4'h0;
            an_complete <= 1'b0;
            an_failed <= 1'b0;
            neg_speed_100 <= 1'b0;
            neg_duplex_full <= 1'b0;
            detect_speed_100 <= 1'b0;
        end
        else
        begin
            last_adv <= adv;
            if (!an_enable || adv != last_adv)
            begin
                cnt <= 4'h0;
                an_complete <= 1'b0;
                an_failed <= 1'b0;
            end
            else if (cnt != 4'h8)
            begin
                cnt <= cnt + 4'h1;
            end
            else if (common == 4'h0)
            begin
                an_failed <= 1'b1;
                detect_speed_100 <= ability[3] | ability[2];
            end
            else
            begin
                an_complete <= 1'b1;
                neg_speed_100 <= common[3] | common[2];
                neg_duplex_full <= common[3] | (!common[2] & common[1]);
            end
        end
    end
endmodule // pac_link_partner

`default_nettype wire

// File: verification/test_phy_autoneg_port_control.sv
// Purpose: Self-checking bench for the negotiation control block
// Assumes: Inputs driven at the falling edge of core_clk
// Notes: Partner models answer negotiation on both ports
`default_nettype none

module test_phy_autoneg_port_control;
    timeunit 1ns;
    timeprecision 1ps;
    import pac_pkg::*;
    // ----------------------------------------------------------------
    // Signals
    // ----------------------------------------------------------------
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic [7:0] reg_rdata;
    logic reg_rd_valid;
    logic [5:0] straps = 6'h2A;
    logic [3:0] abil1 = 4'h3;
    logic [3:0] abil2 = 4'hF;
    logic [1:0] led_a = 2'h0;
    logic [1:0] led_b = 2'h2;
    wire [1:0] an_cmp;
    wire [1:0] an_fail;
    wire [1:0] n_spd;
    wire [1:0] n_dup;
    wire [1:0] d_spd;
    logic [1:0] an_enable, adv_pause, adv_100_full, adv_100_half, adv_10_full, adv_10_half;
    logic [1:0] link_speed_100, link_duplex_full, led_out_a, led_out_b;
    int n_fail = 0;
    int checks = 0;
    int cycles = 0;
    int k;

    always #20 core_clk = ~core_clk;

    pac_autoneg_ctrl u_dut (.core_clk(core_clk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid),
        .port1_led_low_strap(straps[5]), .port1_led_high_strap(straps[4]),
        .port1_duplex_strap(straps[3]), .port2_negotiation_strap(straps[2]),
        .port2_speed_strap(straps[1]), .port2_duplex_strap(straps[0]),
        .an_complete(an_cmp), .an_failed(an_fail), .neg_speed_100(n_spd),
        .neg_duplex_full(n_dup), .detect_speed_100(d_spd), .led_drive_a(led_a),
        .led_drive_b(led_b), .an_enable(an_enable), .adv_pause(adv_pause),
        .adv_100_full(adv_100_full), .adv_100_half(adv_100_half),
        .adv_10_full(adv_10_full), .adv_10_half(adv_10_half),
        .link_speed_100(link_speed_100), .link_duplex_full(link_duplex_full),
        .port_led_output_a(led_out_a), .port_led_output_b(led_out_b));

    pac_link_partner u_lp1 (.core_clk(core_clk), .rst_n(rst_n), .an_enable(an_enable[0]),
        .adv({adv_100_full[0], adv_100_half[0], adv_10_full[0], adv_10_half[0]}),
        .ability(abil1), .an_complete(an_cmp[0]), .an_failed(an_fail[0]),
        .neg_speed_100(n_spd[0]), .neg_duplex_full(n_dup[0]), .detect_speed_100(d_spd[0]));

    pac_link_partner u_lp2 (.core_clk(core_clk), .rst_n(rst_n), .an_enable(an_enable[1]),
        .adv({adv_100_full[1], adv_100_half[1], adv_10_full[1], adv_10_half[1]}),
        .ability(abil2), .an_complete(an_cmp[1]), .an_failed(an_fail[1]),
        .neg_speed_100(n_spd[1]), .neg_duplex_full(n_dup[1]), .detect_speed_100(d_spd[1]));

    // ----------------------------------------------------------------
    // Tasks
    // ----------------------------------------------------------------
    task automatic give_verdict();
        begin
            $display("checks %0d n_fail %0d", checks, n_fail);
            if (n_fail == 0 && checks > 0)
                $display("ALL TESTS PASSED");
            else
                $display("TESTS FAILED");
            $finish;
        end
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        begin
            checks++;
            if (got !== exp)
            begin
                n_fail++;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        begin
            reg_addr = a;
            reg_wdata = d;
            reg_wr_en = 1'b1;
            @(negedge core_clk);
            reg_wr_en = 1'b0;
            @(negedge core_clk);
        end
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        begin
            reg_addr = a;
            reg_rd_en = 1'b1;
            @(negedge core_clk);
            reg_rd_en = 1'b0;
            chk(8'(reg_rd_valid), 8'h01);
            chk(reg_rdata, exp);
            @(negedge core_clk);
        end
    endtask

    task automatic an_wait(input int p);
        int i;
        begin
            repeat (3) @(negedge core_clk);
            for (i = 0; i < 40 && an_cmp[p] !== 1'b1 && an_fail[p] !== 1'b1; i++)
                @(negedge core_clk);
            repeat (3) @(negedge core_clk);
        end
    endtask

    always @(posedge core_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // ----------------------------------------------------------------
    // Tests
    // ----------------------------------------------------------------
    initial
    begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        rd(PAC_P1_NEG_CTRL_OFS, 8'hBF);
        rd(PAC_P2_NEG_CTRL_OFS, 8'h5F);
        rd(PAC_P1_LED_CTRL_OFS, 8'h00);
        rd(PAC_P2_LED_CTRL_OFS, 8'h00);
        chk(8'(an_enable), 8'h01);
        chk(8'(adv_pause), 8'h03);
        wr(8'h3C, 8'hFF);
        rd(8'h3C, 8'h00);
        rd(PAC_P1_NEG_CTRL_OFS, 8'hBF);
        $display("test reset values done");
        for (k = 0; k < 4; k++)
        begin
            wr(PAC_P1_NEG_CTRL_OFS, {1'b0, k[1], k[0], 5'h1F});
            repeat (2) @(negedge core_clk);
            chk(8'(an_enable[0]), 8'h00);
            chk(8'(link_speed_100[0]), 8'(k[1]));
            chk(8'(link_duplex_full[0]), 8'(k[0]));
        end
        $display("test forced mode done");
        for (k = 0; k < 5; k++)
        begin
            wr(PAC_P2_NEG_CTRL_OFS, 8'(1 << k));
            rd(PAC_P2_NEG_CTRL_OFS, 8'(1 << k));
            chk(8'({adv_pause[1], adv_100_full[1], adv_100_half[1], adv_10_full[1],
                adv_10_half[1]}), 8'(1 << k));
        end
        $display("test advertise done");
        // Negotiated result, then failed negotiation using detected speed and the forced duplex bit
        wr(PAC_P1_NEG_CTRL_OFS, 8'h9F);
        an_wait(0);
        chk(8'(link_speed_100[0]), 8'h00);
        chk(8'(link_duplex_full[0]), 8'h01);
        abil1 = 4'h4;
        wr(PAC_P1_NEG_CTRL_OFS, 8'h83);
        an_wait(0);
        chk(8'(link_speed_100[0]), 8'h01);
        chk(8'(link_duplex_full[0]), 8'h00);
        wr(PAC_P1_NEG_CTRL_OFS, 8'hA3);
        repeat (2) @(negedge core_clk);
        chk(8'(link_duplex_full[0]), 8'h01);
        $display("test negotiation done");
        wr(PAC_P1_LED_CTRL_OFS, 8'hFF);
        repeat (2) @(negedge core_clk);
        chk(8'({led_out_a, led_out_b}), 8'h07);
        rd(PAC_P1_LED_CTRL_OFS, 8'h80);
        wr(PAC_P2_LED_CTRL_OFS, 8'h80);
        wr(PAC_P1_LED_CTRL_OFS, 8'h00);
        repeat (2) @(negedge core_clk);
        chk(8'({led_out_a, led_out_b}), 8'h0A);
        $display("test led off done");
        straps = 6'h15;
        rst_n = 1'b0;
        repeat (4) @(negedge core_clk);
        rst_n = 1'b1;
        repeat (2) @(negedge core_clk);
        rd(PAC_P1_NEG_CTRL_OFS, 8'h5F);
        rd(PAC_P2_NEG_CTRL_OFS, 8'hBF);
        rd(PAC_P2_LED_CTRL_OFS, 8'h00);
        an_wait(1);
        chk(8'({link_speed_100[1], link_duplex_full[1]}), 8'h03);
        $display("test second reset done");
        give_verdict();
    end
endmodule // test_phy_autoneg_port_control

`default_nettype wire
